// [core/wake_irq_defs.vh]
`ifndef WAKE_IRQ_DEFS_VH
`define WAKE_IRQ_DEFS_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_RATE_LIMIT 5'h05
`define ADDR_STATUS     5'h08
// ----------------------------------------------------------------
// Command types, top three command bits
// ----------------------------------------------------------------
`define CMD_READ_REG    3'h2
`define CMD_WRITE_REG   3'h3
`define CMD_CLEAR_IRQ   3'h5
// ----------------------------------------------------------------
// Rate and limit configuration fields
// ----------------------------------------------------------------
`define RATE_HI         7
`define RATE_LO         6
`define LIMIT_HI        5
`define LIMIT_LO        0
`define CFG_RESET       8'h9C
`define LIMIT_MIN       6'h0C
`define RATE_X8         2'h0
`define RATE_X4         2'h1
`define RATE_X2         2'h2
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_WAKE         7
`define ST_LOW          6
`define ST_AUX          5
`define ST_KEY_HI       4
`define ST_KEY_LO       0
// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define DEBOUNCE_COUNT  14'h2003
`define BYTE_LAST       3'h7
`define SYNC_FILL       2'h2
`define KEYS_IDLE       5'h1F
`endif

// [core/sync2.v]
`timescale 1ns/1ps
module sync2 #(
  parameter         W         = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input  wire         clk,      // System clock
  input  wire         resetn,   // Async reset, active low
  input  wire [W-1:0] d,        // Asynchronous levels
  output wire [W-1:0] q         // Synchronised levels
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // sync2

// [core/key_debounce.v]
`timescale 1ns/1ps
module key_debounce #(
  parameter N     = 5,
  parameter CW    = 14,
  parameter LIMIT = 14'h2003
) (
  input  wire         clk,      // System clock
  input  wire         resetn,   // Async reset, active low
  input  wire         enable,   // Device in an active mode
  input  wire         tick,     // One base clock period
  input  wire [N-1:0] keys,     // Synchronised key levels
  output reg          running,  // Counter running
  output reg          done      // Debounce complete pulse
);
  reg [N-1:0] prev_reg;
  reg [CW-1:0] count_reg;
  reg [2:0]   key_reg;
  wire [N-1:0] ev = enable ? (keys ^ prev_reg) : {N{1'b0}};

  function [N-1:0] key_mask;
    input [2:0] k;
    begin
      key_mask = {{(N-1){1'b0}}, 1'b1} << k;
    end
  endfunction

  // Events on keys other than the one being debounced
  wire [N-1:0] others = ev & ~key_mask(key_reg);
  wire         other  = |others;

  function [2:0] first_one;
    input [N-1:0] v;
    integer i;
    begin
      first_one = 3'h0;
      for (i = N - 1; i >= 0; i = i - 1)
        if (v[i]) first_one = i[2:0];
    end
  endfunction

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg  <= {N{1'b1}};
      count_reg <= {CW{1'b0}};
      key_reg   <= 3'h0;
      running   <= 1'b0;
      done      <= 1'b0;
    end else begin
      prev_reg <= keys;
      done     <= 1'b0;
      if (|ev) begin
        if (running && !other) begin
          running <= 1'b0;
        end else begin
          running   <= 1'b1;
          count_reg <= {CW{1'b0}};
          key_reg   <= first_one(other ? others : ev);
        end
      end else if (running && tick) begin
        if (count_reg == LIMIT - 1) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end
endmodule // key_debounce

// [core/wake_status_irq_logic.v]
// Contract
// - Rate field bits 7:6 scale base period by 8, 4, 2, 1; reset code 10.
// - Limit field bits 5:0 gives (value-1) scaled periods; below 12 refused; reset 28.
// - Eight-bit status register readable at address 8 over serial port.
// - Interrupt on wake flag set, aux flag set, or debounced key event.
// - Status read clears wake, supply-low, aux flags and interrupt.
// - Key status bits read inverted key level; key wake sets bit and interrupt.
// - Key event zeroes and starts debounce; at 8195 periods update, interrupt, stop.
// - Same key event during debounce stops counter without update.
// - Other key event during debounce restarts counter from zero.
// - Running debounce forces supply and clock-output enables high.
// - Key interrupt cleared by status read or clear-interrupt command.
// - Wake pin rising edge sets wake flag; interrupt only on flag 0 to 1.
// - Wake flag high forces supply and clock-output enables high.
// - Wake pin falling has no effect on mode.
// - Aux rise in non-aux active modes sets aux flag; interrupt on 0 to 1.
// - Supply-low sets on low; clears only when restored and status read.
// - Wake from off by wake pin sets flag and interrupt once logic is active.
// - Wake from off with aux detector high sets aux flag and raises interrupt.
// - Command with top bits 101 drives interrupt low.
`timescale 1ns/1ps
`include "wake_irq_defs.vh"
module wake_status_irq_logic #(
  parameter BASE_DIV       = 8'h01,
  parameter DEBOUNCE_COUNT = `DEBOUNCE_COUNT
) (
  input  wire       sys_clk,           // System clock, 200 MHz
  input  wire       resetn,            // Async reset, active low
  input  wire       cs,                // Serial select, high active
  input  wire       sck,               // Serial clock
  input  wire       sdi,               // Serial data in, MSB first
  output wire       sdo,               // Serial data out
  output wire       sdo_oe,            // Serial data output enable
  input  wire [4:0] key_input_n,       // Key inputs, low = pressed
  input  wire       wake_pin,          // Wake pin level
  input  wire       aux_supply_pin,    // Aux supply detector, high = ok
  input  wire       supply_low,        // Ext supply comparator, high = low
  input  wire       active_mode,       // Device in an active mode
  input  wire       aux_mode,          // Device in aux mode
  input  wire       limit_extend,      // Doubles the scaled period
  input  wire       limit_restart,     // Restarts the limit timer
  output wire       irq,               // Interrupt to host, high active
  output wire       ext_supply_force,  // Forces ext supply enable
  output wire       clk_out_force,     // Forces clock output enable
  output wire       scaled_clk_tick,   // One scaled data clock period
  output wire       limit_expired,     // Limit time elapsed
  output wire [1:0] rate_range,        // Bit-rate range field
  output wire [5:0] max_limit          // Max pulse limit field
);
  // --------------------------------------------------------------
  // Serial states
  // --------------------------------------------------------------
  localparam PH_CMD = 4'b0001;
  localparam PH_RD  = 4'b0010;
  localparam PH_WR  = 4'b0100;
  localparam PH_IGN = 4'b1000;

  wire [6:0] sync_q;
  wire [4:0] keys_s = sync_q[4:0];
  wire       wake_s = sync_q[5];
  wire       aux_s  = sync_q[6];

  reg  [7:0] cfg_reg;
  reg        wake_flag_reg;
  reg        low_flag_reg;
  reg        aux_flag_reg;
  reg  [4:0] key_state_reg;
  reg        irq_reg;
  reg        wake_prev_reg;
  reg        aux_prev_reg;
  reg  [1:0] start_cnt_reg;
  reg        started_reg;
  reg        force_reg;
  reg  [3:0] phase_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [6:0] rx_reg;
  reg  [7:0] tx_reg;
  reg  [4:0] addr_reg;
  reg        sck_prev_reg;
  reg        sdo_reg;
  reg        sdo_oe_reg;
  reg  [7:0] base_cnt_reg;
  reg  [4:0] scale_cnt_reg;
  reg        scaled_tick_reg;
  reg  [5:0] limit_cnt_reg;
  reg        limit_exp_reg;

  wire       deb_running;
  wire       deb_done;

  // --------------------------------------------------------------
  // Input synchronisers and key debounce
  // --------------------------------------------------------------
  sync2 #(
    .W         (7),
    .RESET_VAL ({2'b00, `KEYS_IDLE})
  ) u_sync (
    .clk    (sys_clk),
    .resetn (resetn),
    .d      ({aux_supply_pin, wake_pin, key_input_n}),
    .q      (sync_q)
  );

  wire base_tick = (base_cnt_reg == BASE_DIV - 1'b1);

  key_debounce #(
    .N     (5),
    .CW    (14),
    .LIMIT (DEBOUNCE_COUNT)
  ) u_deb (
    .clk     (sys_clk),
    .resetn  (resetn),
    .enable  (active_mode & started_reg),
    .tick    (base_tick),
    .keys    (keys_s),
    .running (deb_running),
    .done    (deb_done)
  );

  // --------------------------------------------------------------
  // Rate scaling
  // --------------------------------------------------------------
  function [4:0] scale_factor;
    input [1:0] rate;
    input       ext;
    reg   [4:0] f;
    begin
      case (rate)
        `RATE_X8: f = 5'h08;
        `RATE_X4: f = 5'h04;
        `RATE_X2: f = 5'h02;
        default:  f = 5'h01;
      endcase
      scale_factor = ext ? {f[3:0], 1'b0} : f;
    end
  endfunction

  wire [4:0] scale_last = scale_factor(cfg_reg[`RATE_HI:`RATE_LO], limit_extend) - 1'b1;

  // --------------------------------------------------------------
  // Serial decode
  // --------------------------------------------------------------
  wire       sck_rise  = cs && sck && !sck_prev_reg;
  wire       sck_fall  = cs && !sck && sck_prev_reg;
  wire       byte_done = sck_rise && (bit_cnt_reg == `BYTE_LAST);
  wire [7:0] byte_in   = {rx_reg, sdi};
  wire [2:0] cmd_type  = byte_in[7:5];
  wire [4:0] look_addr = (phase_reg == PH_CMD) ? byte_in[4:0] : addr_reg + 1'b1;
  wire       rd_load   = byte_done &&
                         ((phase_reg == PH_CMD && cmd_type == `CMD_READ_REG) ||
                          phase_reg == PH_RD);
  wire       status_rd = rd_load && (look_addr == `ADDR_STATUS);
  wire       clr_cmd   = byte_done && phase_reg == PH_CMD &&
                         cmd_type == `CMD_CLEAR_IRQ;
  wire       cfg_wr    = byte_done && phase_reg == PH_WR &&
                         addr_reg == `ADDR_RATE_LIMIT;

  reg  [7:0] status_vec;
  reg  [7:0] rd_byte;

  always @* begin
    status_vec = 8'h00;
    status_vec[`ST_WAKE] = wake_flag_reg;
    status_vec[`ST_LOW]  = low_flag_reg;
    status_vec[`ST_AUX]  = aux_flag_reg;
    status_vec[`ST_KEY_HI:`ST_KEY_LO] = key_state_reg;
    case (look_addr)
      `ADDR_RATE_LIMIT: rd_byte = cfg_reg;
      `ADDR_STATUS:     rd_byte = status_vec;
      default:          rd_byte = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg    <= PH_CMD;
      bit_cnt_reg  <= 3'h0;
      rx_reg       <= 7'h00;
      tx_reg       <= 8'h00;
      addr_reg     <= 5'h00;
      sck_prev_reg <= 1'b0;
      sdo_reg      <= 1'b0;
      sdo_oe_reg   <= 1'b0;
    end else begin
      sck_prev_reg <= sck;
      // Enable leaves on a flop, one cycle behind select
      sdo_oe_reg   <= cs;
      if (!cs) begin
        // Interface held in reset while deselected
        phase_reg   <= PH_CMD;
        bit_cnt_reg <= 3'h0;
        tx_reg      <= 8'h00;
        sdo_reg     <= 1'b0;
      end else if (sck_rise) begin
        rx_reg      <= byte_in[6:0];
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        if (byte_done) begin
          case (phase_reg)
            PH_CMD: begin
              addr_reg <= byte_in[4:0];
              case (cmd_type)
                `CMD_READ_REG: begin
                  phase_reg <= PH_RD;
                  tx_reg    <= rd_byte;
                end
                `CMD_WRITE_REG: begin
                  phase_reg <= PH_WR;
                  tx_reg    <= byte_in;
                end
                default: begin
                  phase_reg <= PH_IGN;
                  tx_reg    <= 8'h00;
                end
              endcase
            end
            PH_RD: begin
              addr_reg <= look_addr;
              tx_reg   <= rd_byte;
            end
            PH_WR: begin
              addr_reg <= addr_reg + 1'b1;
              tx_reg   <= byte_in;
            end
            default: tx_reg <= 8'h00;
          endcase
        end
      end else if (sck_fall) begin
        sdo_reg <= tx_reg[7];
        tx_reg  <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------
  // A limit below the minimum is refused; the rate field still takes.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= `CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg[`RATE_HI:`RATE_LO] <= byte_in[`RATE_HI:`RATE_LO];
      if (byte_in[`LIMIT_HI:`LIMIT_LO] >= `LIMIT_MIN)
        cfg_reg[`LIMIT_HI:`LIMIT_LO] <= byte_in[`LIMIT_HI:`LIMIT_LO];
    end
  end

  // --------------------------------------------------------------
  // Scaled data clock and limit timer
  // --------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      base_cnt_reg    <= 8'h00;
      scale_cnt_reg   <= 5'h00;
      scaled_tick_reg <= 1'b0;
      limit_cnt_reg   <= 6'h00;
      limit_exp_reg   <= 1'b0;
    end else begin
      base_cnt_reg    <= base_tick ? 8'h00 : base_cnt_reg + 1'b1;
      scaled_tick_reg <= 1'b0;
      if (base_tick) begin
        if (scale_cnt_reg >= scale_last) begin
          scale_cnt_reg   <= 5'h00;
          scaled_tick_reg <= 1'b1;
        end else begin
          scale_cnt_reg <= scale_cnt_reg + 1'b1;
        end
      end
      if (limit_restart) begin
        limit_cnt_reg <= 6'h00;
        limit_exp_reg <= 1'b0;
      end else if (scaled_tick_reg && !limit_exp_reg) begin
        limit_cnt_reg <= limit_cnt_reg + 1'b1;
        if (limit_cnt_reg + 1'b1 >= cfg_reg[`LIMIT_HI:`LIMIT_LO] - 1'b1)
          limit_exp_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Status flags and interrupt
  // --------------------------------------------------------------
  // Levels are caught once the synchronisers have filled after reset,
  // standing in for a wake from off by key, wake pin or aux supply.
  wire startup  = !started_reg && (start_cnt_reg == `SYNC_FILL);
  wire live     = started_reg && active_mode;
  wire key_wake = startup && (keys_s != `KEYS_IDLE);
  // Falling wake pin deliberately has no effect here
  wire wake_set = (live && wake_s && !wake_prev_reg) ||
                  (startup && wake_s);
  wire aux_set  = (live && !aux_mode && aux_s && !aux_prev_reg) ||
                  (startup && aux_s);
  wire irq_set  = (wake_set && !wake_flag_reg) ||
                  (aux_set && !aux_flag_reg) ||
                  deb_done || key_wake;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
      aux_flag_reg  <= 1'b0;
      key_state_reg <= 5'h00;
      irq_reg       <= 1'b0;
      wake_prev_reg <= 1'b0;
      aux_prev_reg  <= 1'b0;
      start_cnt_reg <= 2'h0;
      started_reg   <= 1'b0;
      force_reg     <= 1'b0;
    end else begin
      wake_prev_reg <= wake_s;
      aux_prev_reg  <= aux_s;
      if (!started_reg)
        start_cnt_reg <= start_cnt_reg + 1'b1;
      if (startup)
        started_reg <= 1'b1;
      // Set wins over a read in the same cycle for every flag
      if (wake_set)
        wake_flag_reg <= 1'b1;
      else if (status_rd)
        wake_flag_reg <= 1'b0;
      if (aux_set)
        aux_flag_reg <= 1'b1;
      else if (status_rd)
        aux_flag_reg <= 1'b0;
      if (supply_low)
        low_flag_reg <= 1'b1;
      else if (status_rd)
        low_flag_reg <= 1'b0;
      if (deb_done || key_wake)
        key_state_reg <= ~keys_s;
      if (irq_set)
        irq_reg <= 1'b1;
      else if (status_rd || clr_cmd)
        irq_reg <= 1'b0;
      force_reg <= wake_flag_reg || deb_running;
    end
  end

  assign sdo              = sdo_reg;
  assign sdo_oe           = sdo_oe_reg;
  assign irq              = irq_reg;
  assign ext_supply_force = force_reg;
  assign clk_out_force    = force_reg;
  assign scaled_clk_tick  = scaled_tick_reg;
  assign limit_expired    = limit_exp_reg;
  assign rate_range       = cfg_reg[`RATE_HI:`RATE_LO];
  assign max_limit        = cfg_reg[`LIMIT_HI:`LIMIT_LO];
endmodule // wake_status_irq_logic

// [bench/wake_irq_monitor.sv]
`timescale 1ns/1ps
module wake_irq_monitor (
  input wire       sys_clk,          // System clock
  input wire       resetn,           // Async reset, active low
  input wire       cs,               // Serial select
  input wire       sdo_oe,           // Serial output enable
  input wire [4:0] key_input_n,      // Key levels
  input wire       wake_pin,         // Wake pin level
  input wire       aux_supply_pin,   // Aux detector
  input wire       active_mode,      // Active mode
  input wire       aux_mode,         // Aux mode
  input wire       irq,              // Interrupt
  input wire       ext_supply_force, // Supply enable force
  input wire       clk_out_force,    // Clock output force
  input wire [1:0] rate_range,       // Rate field
  input wire [5:0] max_limit         // Limit field
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_oe_follows_cs:
    assert property (sdo_oe == $past(cs)) else $error("sdo enable differs from select");
  chk_force_pair:
    assert property (clk_out_force == ext_supply_force) else $error("force outputs differ");
  chk_wake_sets_irq:
    assert property ($rose(wake_pin) && active_mode && !ext_supply_force |-> ##[1:6] irq)
    else $error("wake edge gave no interrupt");
  chk_wake_forces:
    assert property ($rose(wake_pin) && active_mode |-> ##[1:6] ext_supply_force)
    else $error("wake flag did not force enables");
  chk_aux_sets_irq:
    assert property ($rose(aux_supply_pin) && active_mode && !aux_mode && !irq |-> ##[1:6] irq)
    else $error("aux edge gave no interrupt");
  chk_irq_clear_cs:
    assert property ($fell(irq) |-> $past(cs)) else $error("interrupt fell without host access");
  chk_limit_floor:
    assert property (max_limit >= 6'h0C) else $error("limit field below floor");
  chk_cfg_by_host:
    assert property ($changed({rate_range, max_limit}) |-> $past(cs))
    else $error("config changed without host access");
  chk_key_forces:
    assert property ($changed(key_input_n) && active_mode |-> ##[1:6] ext_supply_force)
    else $error("debounce did not force enables");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property ($rose(ext_supply_force));
endmodule // wake_irq_monitor

// [bench/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
  input  wire sys_clk, // System clock
  input  wire sdo,     // Serial data from device
  input  wire sdo_oe,  // Device drives sdo
  output reg  cs,      // Select
  output reg  sck,     // Serial clock
  output reg  sdi      // Serial data to device
);
  initial begin
    cs = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Each sck phase lasts 4 sys_clk cycles, twice the minimum, so edges are never missed
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge sys_clk);
      rx[i] = sdo_oe ? sdo : 1'b1;
      sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  // Lower command bits carry no meaning for a clear
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input bit two,
                      output logic [7:0] rd);
    logic [7:0] echo;
    @(posedge sys_clk);
    cs <= 1'b1;
    shift(cmd, echo);
    if (two) shift(wd, rd);
    @(posedge sys_clk);
    sck <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cs <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // serial_host_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic       sys_clk, resetn, cs, sck, sdi, sdo, sdo_oe, wake_pin, aux_supply_pin;
  logic       supply_low, active_mode, aux_mode, limit_extend, limit_restart, irq;
  logic       ext_supply_force, clk_out_force, scaled_clk_tick, limit_expired;
  logic [4:0] key_input_n;
  logic [1:0] rate_range;
  logic [5:0] max_limit;
  integer     failures, total_checks, r, n;

  wake_status_irq_logic #(.BASE_DIV(8'h01), .DEBOUNCE_COUNT(14'h0014)) dut (
    .sys_clk, .resetn, .cs, .sck, .sdi, .sdo, .sdo_oe, .key_input_n, .wake_pin,
    .aux_supply_pin, .supply_low, .active_mode, .aux_mode, .limit_extend, .limit_restart,
    .irq, .ext_supply_force, .clk_out_force, .scaled_clk_tick, .limit_expired,
    .rate_range, .max_limit);
  serial_host_model host (.sys_clk, .sdo, .sdo_oe, .cs, .sck, .sdi);

  always #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic st(input logic [7:0] exp);
    chk({5'h00, irq, ext_supply_force, clk_out_force}, exp);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer({3'h2, a}, 8'h00, 1'b1, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer({3'h3, a}, d, 1'b1, q);
  endtask
  task automatic clr;
    logic [7:0] q;
    host.xfer(8'hA5, 8'h00, 1'b0, q);
  endtask
  task automatic period(output integer k);
    k = 0;
    @(posedge sys_clk iff scaled_clk_tick);
    do begin
      @(posedge sys_clk);
      k++;
    end while (!scaled_clk_tick);
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0; total_checks = 0; sys_clk = 1'b0; resetn = 1'b0;
    key_input_n = 5'h1F; wake_pin = 1'b0; aux_supply_pin = 1'b0; supply_low = 1'b0;
    active_mode = 1'b1; aux_mode = 1'b0; limit_extend = 1'b0; limit_restart = 1'b0;
    cyc(20);
    resetn <= 1'b1;
    cyc(5);
    chk({rate_range, max_limit}, 8'h9C);
    rdchk(5'h05, 8'h9C);
    rdchk(5'h08, 8'h00);
    rdchk(5'h09, 8'h00);
    wr(5'h05, 8'hC5);
    chk({rate_range, max_limit}, 8'hDC);
    // Range 3 only exercises tick timing; no ASK reception runs here
    for (r = 0; r < 8; r++) begin
      limit_extend <= r[2];
      wr(5'h05, {r[1:0], 6'h0C});
      rdchk(5'h05, {r[1:0], 6'h0C});
      period(n);
      chk(n[7:0], (8'h08 >> r[1:0]) << r[2]);
    end
    limit_extend <= 1'b0;
    wr(5'h05, 8'h0C);
    limit_restart <= 1'b1;
    cyc(1);
    limit_restart <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n += scaled_clk_tick;
    end while (!limit_expired);
    chk(n[7:0], 8'h0B);
    wake_pin <= 1'b1;
    cyc(8);
    st(8'h07);
    rdchk(5'h08, 8'h80);
    cyc(3);
    st(8'h00);
    wake_pin <= 1'b0;
    cyc(8);
    st(8'h00);
    wake_pin <= 1'b1;
    cyc(8);
    clr();
    st(8'h03);
    wake_pin <= 1'b0;
    cyc(8);
    wake_pin <= 1'b1;
    cyc(8);
    st(8'h03);
    rdchk(5'h08, 8'h80);
    aux_supply_pin <= 1'b1;
    cyc(8);
    st(8'h04);
    rdchk(5'h08, 8'h20);
    aux_supply_pin <= 1'b0;
    aux_mode <= 1'b1;
    cyc(8);
    aux_supply_pin <= 1'b1;
    cyc(8);
    st(8'h00);
    aux_mode <= 1'b0;
    supply_low <= 1'b1;
    cyc(6);
    rdchk(5'h08, 8'h40);
    rdchk(5'h08, 8'h40);
    supply_low <= 1'b0;
    cyc(4);
    rdchk(5'h08, 8'h40);
    rdchk(5'h08, 8'h00);
    key_input_n <= 5'h1E;
    cyc(18);
    st(8'h03);
    cyc(12);
    st(8'h04);
    rdchk(5'h08, 8'h01);
    key_input_n <= 5'h1C;
    cyc(5);
    key_input_n <= 5'h1E;
    cyc(40);
    st(8'h00);
    key_input_n <= 5'h1A;
    cyc(10);
    key_input_n <= 5'h12;
    cyc(18);
    st(8'h03);
    cyc(12);
    st(8'h04);
    clr();
    st(8'h00);
    rdchk(5'h08, 8'h0D);
    key_input_n <= 5'h1F;
    cyc(40);
    // Second reset models a wake from off with the wake pin and key 0 held;
    // the aux detector is still high from the aux tests, so its flag sets too
    resetn <= 1'b0;
    wake_pin <= 1'b1;
    key_input_n <= 5'h1E;
    cyc(2);
    resetn <= 1'b1;
    cyc(8);
    st(8'h07);
    rdchk(5'h08, 8'hA1);
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    end_sim;
  end
endmodule // tb

bind wake_status_irq_logic wake_irq_monitor mon (
  .sys_clk, .resetn, .cs, .sdo_oe, .key_input_n, .wake_pin, .aux_supply_pin, .active_mode,
  .aux_mode, .irq, .ext_supply_force, .clk_out_force, .rate_range, .max_limit);
